// [src/ebc_top.sv]
// External bus configuration, pin functions and chip-select generation.
// Assumes a 100 MHz bus clock, config writes and bus requests from core
// logic on that clock, and boot/width straps on raw pins.
`timescale 1ns/1ps

// Behaviour
// - Processor mode resets to microprocessor code
// - Soft or watchdog reset keeps processor mode
// - Control register 0 writes need unlock bit
// - One width bit per external space
// - Space 3 width follows width strap
// - Separate bus format after reset
// - Port 1 carries data if any 16-bit
// - Multiplexed area shares 8 or 16 lines
// - Mux codes: separate, CS2 area, CS1 area
// - 24-bit address, top bit inverted
// - Chip selects share top four address pins
// - No chip selects after reset
// - Select low for own space, else high
// - Selects 1,2,3,0 map to spaces 0-3
// - Same space keeps select, address updates
// - Internal access drops select, holds address
// - Strobe style picks write strobe set
// - Latch pin undefined when no latch
// - Bus clock pin enable conditions
// - 8-bit space forces read/write/upper-enable strobes
module ebc_top (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                soft_reset,
  input  wire logic                boot_mode_pin,
  input  wire logic                byte_width_pin,
  input  wire logic                protect_wr,
  input  wire logic                protect_unlock,
  input  wire logic                ctrl0_wr,
  input  wire ebc_pkg::ebc_ctrl0_t ctrl0_wdata,
  input  wire logic                ctrl1_wr,
  input  wire ebc_pkg::ebc_ctrl1_t ctrl1_wdata,
  input  wire logic                width_wr,
  input  wire logic [3:0]          width_wdata,
  input  wire logic [1:0]          clock_out_sel,
  input  wire ebc_pkg::ebc_access_t acc,
  output ebc_pkg::ebc_ctrl0_t      ctrl0,
  output ebc_pkg::ebc_ctrl1_t      ctrl1,
  output logic                     mode_reg_unlock,
  output logic [3:0]               space_width,
  output logic                     boot_mode_seen,
  output logic [19:0]              addr_pins,
  output logic [3:0]               hi_pins,
  output logic [3:0]               cs_n,
  output logic [2:0]               strobe_n,
  output logic                     port1_is_data,
  output logic [1:0]               mux_lines,
  output logic                     latch_p53,
  output logic                     latch_p54,
  output logic                     latch_p56,
  output logic                     clock_output_pin_en
);
  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Strap pins cross into the clock domain first
  logic boot_sync;
  logic byte_sync;

  ebc_sync2 #(.W(1)) u_boot_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (boot_mode_pin),
    .dout  (boot_sync)
  );

  ebc_sync2 #(.W(1)) u_byte_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (byte_width_pin),
    .dout  (byte_sync)
  );

  // ---------------- Configuration state ----------------
  ebc_pkg::ebc_ctrl0_t ctrl0_reg;
  ebc_pkg::ebc_ctrl0_t ctrl0_next;
  ebc_pkg::ebc_ctrl1_t ctrl1_reg;
  ebc_pkg::ebc_ctrl1_t ctrl1_next;
  logic                unlock_reg;
  logic                unlock_next;
  logic [3:0]          width_reg;
  logic [3:0]          width_next;
  logic [1:0]          strap_cnt_reg;
  logic [1:0]          strap_cnt_next;
  logic                strap_done_reg;
  logic                strap_done_next;
  logic                boot_seen_reg;
  logic                boot_seen_next;

  // Config updates; strap caught once the synchroniser has filled
  always_comb begin
    ctrl0_next      = ctrl0_reg;
    ctrl1_next      = ctrl1_reg;
    unlock_next     = unlock_reg;
    width_next      = width_reg;
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    boot_seen_next  = boot_seen_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == ebc_pkg::EBC_STRAP_WAIT) begin
        strap_done_next = 1'b1;
        boot_seen_next  = boot_sync;
        width_next[ebc_pkg::EBC_SPACE3] = ~byte_sync;
      end else begin
        strap_cnt_next = strap_cnt_reg + ebc_pkg::EBC_CS_STEP;
      end
    end
    if (soft_reset) begin
      // All config state returns to reset except the processor mode and the strap capture
      ctrl0_next.bus_clock_out_disable = 1'b0;
      ctrl0_next.mux_select       = ebc_pkg::EBC_MUX_SEP;
      ctrl0_next.strobe_style_sel = 1'b0;
      ctrl0_next.proc_mode        = ctrl0_reg.proc_mode;
      ctrl1_next.space_mode       = ebc_pkg::EBC_SPACE_MODE_RST;
      ctrl1_next.latch_pin_sel    = ebc_pkg::EBC_LATCH_NONE;
      unlock_next                 = 1'b0;
      width_next                  = ebc_pkg::EBC_WIDTH_RST;
      width_next[ebc_pkg::EBC_SPACE3] = ~byte_sync;
    end else begin
      if (ctrl0_wr && unlock_reg) begin
        ctrl0_next = ctrl0_wdata;
      end
      if (ctrl1_wr) begin
        ctrl1_next = ctrl1_wdata;
      end
      if (protect_wr) begin
        unlock_next = protect_unlock;
      end
      if (width_wr) begin
        width_next = width_wdata;
      end
    end
  end

  // Hardware reset only; processor mode lands on its single legal code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg.bus_clock_out_disable <= 1'b0;
      ctrl0_reg.mux_select            <= ebc_pkg::EBC_MUX_SEP;
      ctrl0_reg.strobe_style_sel      <= 1'b0;
      ctrl0_reg.proc_mode             <= ebc_pkg::EBC_PROC_MODE_RST;
      ctrl1_reg.space_mode            <= ebc_pkg::EBC_SPACE_MODE_RST;
      ctrl1_reg.latch_pin_sel         <= ebc_pkg::EBC_LATCH_NONE;
      unlock_reg                      <= 1'b0;
      width_reg                       <= ebc_pkg::EBC_WIDTH_RST;
      strap_cnt_reg                   <= 2'h0;
      strap_done_reg                  <= 1'b0;
      boot_seen_reg                   <= 1'b0;
    end else begin
      ctrl0_reg      <= ctrl0_next;
      ctrl1_reg      <= ctrl1_next;
      unlock_reg     <= unlock_next;
      width_reg      <= width_next;
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      boot_seen_reg  <= boot_seen_next;
    end
  end

  // ---------------- Bus cycle pins ----------------
  logic       hit;
  logic [1:0] space_idx;

  ebc_space_decode u_decode (
    .addr_top   (acc.addr[23:16]),
    .space_mode (ctrl1_reg.space_mode),
    .hit        (hit),
    .space_idx  (space_idx)
  );

  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [3:0]  cs_reg;
  logic [3:0]  cs_next;
  logic [3:0]  hi_reg;
  logic [3:0]  hi_next;
  logic [2:0]  strobe_reg;
  logic [2:0]  strobe_next;
  logic [1:0]  muxl_reg;
  logic [1:0]  muxl_next;
  logic        p1_reg;
  logic        p1_next;
  logic [2:0]  latch_reg;
  logic [2:0]  latch_next;
  logic        clk_en_reg;
  logic        clk_en_next;
  logic [3:0]  cs_mask;
  logic [1:0]  cs_idx;
  logic        w16;
  logic        split;
  logic        muxed;
  logic        ext;

  // Pin values for the cycle now requested
  always_comb begin
    cs_mask     = ebc_pkg::EBC_CS_MASK[ctrl1_reg.space_mode];
    cs_idx      = space_idx + ebc_pkg::EBC_CS_STEP;
    w16         = width_reg[space_idx];
    ext         = acc.valid && !acc.internal;
    addr_next   = addr_reg;
    cs_next     = cs_reg;
    strobe_next = ebc_pkg::EBC_STROBE_IDLE;
    muxl_next   = muxl_reg;
    split       = ctrl0_reg.strobe_style_sel && w16;
    // Only the two legal mux codes select an area; others run separate
    muxed = hit && cs_mask[cs_idx] &&
            (((ctrl0_reg.mux_select == ebc_pkg::EBC_MUX_CS2) && (cs_idx == 2'h2)) ||
             ((ctrl0_reg.mux_select == ebc_pkg::EBC_MUX_CS1) && (cs_idx == 2'h1)));
    if (acc.valid && acc.internal) begin
      cs_next = ebc_pkg::EBC_CS_IDLE;
    end else if (ext) begin
      addr_next = acc.addr;
      cs_next   = ebc_pkg::EBC_CS_IDLE;
      muxl_next = ebc_pkg::EBC_MUXL_NONE;
      if (hit) begin
        cs_next[cs_idx] = !cs_mask[cs_idx];
        strobe_next[0]  = acc.write;
        if (split) begin
          strobe_next[1] = !(acc.write && acc.byte_en[0]);
          strobe_next[2] = !(acc.write && acc.byte_en[1]);
        end else begin
          strobe_next[1] = !acc.write;
          strobe_next[2] = w16 ? !acc.byte_en[1] : 1'b1;
        end
        if (muxed) begin
          muxl_next = w16 ? ebc_pkg::EBC_MUXL_16 : ebc_pkg::EBC_MUXL_8;
        end
      end
    end
    // Shared pins: P4_4..P4_7 carry select 3..0 or A20..A22 and inverted A23
    hi_next[0] = cs_mask[3] ? cs_next[3] : addr_next[20];
    hi_next[1] = cs_mask[2] ? cs_next[2] : addr_next[21];
    hi_next[2] = cs_mask[1] ? cs_next[1] : addr_next[22];
    hi_next[3] = cs_mask[0] ? cs_next[0] : !addr_next[23];
    p1_next    = |width_reg;
    // Latch strobe goes out on every request, internal ones too
    latch_next[0] = acc.valid && (ctrl1_reg.latch_pin_sel == ebc_pkg::EBC_LATCH_P53);
    latch_next[1] = acc.valid && (ctrl1_reg.latch_pin_sel == ebc_pkg::EBC_LATCH_P54);
    latch_next[2] = acc.valid && (ctrl1_reg.latch_pin_sel == ebc_pkg::EBC_LATCH_P56);
    clk_en_next = !ctrl0_reg.bus_clock_out_disable &&
                  (clock_out_sel == ebc_pkg::EBC_CLOCK_OUTPUT_PIN_BCLK) &&
                  (ctrl1_reg.latch_pin_sel != ebc_pkg::EBC_LATCH_P53);
  end

  // Idle pins after reset: selects high, top line inverted from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg   <= 24'h000000;
      cs_reg     <= ebc_pkg::EBC_CS_IDLE;
      hi_reg     <= 4'h8;
      strobe_reg <= ebc_pkg::EBC_STROBE_IDLE;
      muxl_reg   <= ebc_pkg::EBC_MUXL_NONE;
      p1_reg     <= 1'b0;
      latch_reg  <= 3'h0;
      clk_en_reg <= 1'b0;
    end else begin
      addr_reg   <= addr_next;
      cs_reg     <= cs_next;
      hi_reg     <= hi_next;
      strobe_reg <= strobe_next;
      muxl_reg   <= muxl_next;
      p1_reg     <= p1_next;
      latch_reg  <= latch_next;
      clk_en_reg <= clk_en_next;
    end
  end

  // Every output is a flop copy
  assign ctrl0               = ctrl0_reg;
  assign ctrl1               = ctrl1_reg;
  assign mode_reg_unlock     = unlock_reg;
  assign space_width         = width_reg;
  assign boot_mode_seen      = boot_seen_reg;
  assign addr_pins           = addr_reg[19:0];
  assign hi_pins             = hi_reg;
  assign cs_n                = cs_reg;
  assign strobe_n            = strobe_reg;
  assign port1_is_data       = p1_reg;
  assign mux_lines           = muxl_reg;
  assign latch_p53           = latch_reg[0];
  assign latch_p54           = latch_reg[1];
  assign latch_p56           = latch_reg[2];
  assign clock_output_pin_en = clk_en_reg;
endmodule // ebc_top

// [pkg/ebc_pkg.sv]
// Constants, carriers and the chip-select memory map of the external bus block.
// Assumes one bus clock; every consumer names items as ebc_pkg::name.
package ebc_pkg;

  // Processor-mode field: microprocessor mode is the only legal code
  localparam logic [1:0] EBC_PROC_MODE_RST = 2'h3;

  // Multiplex-select codes
  localparam logic [1:0] EBC_MUX_SEP = 2'h0;
  localparam logic [1:0] EBC_MUX_CS2 = 2'h1;
  localparam logic [1:0] EBC_MUX_CS1 = 2'h2;

  // Latch strobe pin codes
  localparam logic [1:0] EBC_LATCH_NONE = 2'h0;
  localparam logic [1:0] EBC_LATCH_P53  = 2'h1;
  localparam logic [1:0] EBC_LATCH_P54  = 2'h2;
  localparam logic [1:0] EBC_LATCH_P56  = 2'h3;

  // Clock-out select code that frees the shared pin for the bus clock
  localparam logic [1:0] EBC_CLOCK_OUTPUT_PIN_BCLK = 2'h0;

  // Reset values and strap timing
  localparam logic [3:0] EBC_WIDTH_RST   = 4'h0;
  localparam logic [1:0] EBC_SPACE_MODE_RST = 2'h0;
  localparam logic [1:0] EBC_SPACE3      = 2'h3;
  localparam logic [1:0] EBC_STRAP_WAIT  = 2'h2;
  localparam logic [1:0] EBC_CS_STEP     = 2'h1;
  localparam logic [2:0] EBC_STROBE_IDLE = 3'h7;
  localparam logic [3:0] EBC_CS_IDLE     = 4'hF;

  // Multiplexed line counts: eight or sixteen shared lines
  localparam logic [1:0] EBC_MUXL_NONE = 2'h0;
  localparam logic [1:0] EBC_MUXL_8    = 2'h1;
  localparam logic [1:0] EBC_MUXL_16   = 2'h3;

  // Active chip selects per space mode, index [mode], bit = select number
  localparam logic [3:0][3:0] EBC_CS_MASK = {4'hF, 4'h3, 4'h7, 4'h0};

  // Space decode table on address bits 23..16, index [mode][space]
  // An empty space has its low bound above its high bound
  localparam logic [3:0][3:0][7:0] EBC_MAP_LO = {
    {8'hF0, 8'hC0, 8'h20, 8'h10},
    {8'hC0, 8'hFF, 8'hFF, 8'h01},
    {8'hE0, 8'hFF, 8'h20, 8'h01},
    {8'hC0, 8'h40, 8'h20, 8'h01}};
  localparam logic [3:0][3:0][7:0] EBC_MAP_HI = {
    {8'hFF, 8'hCF, 8'h2F, 8'h1F},
    {8'hFF, 8'h00, 8'h00, 8'h3F},
    {8'hFF, 8'h00, 8'h3F, 8'h1F},
    {8'hFF, 8'hBF, 8'h3F, 8'h1F}};

  // One bus cycle request from the core
  typedef struct packed {
    logic        valid;
    logic        internal;
    logic        write;
    logic [1:0]  byte_en;
    logic [23:0] addr;
  } ebc_access_t;

  // First processor-mode control register
  typedef struct packed {
    logic       bus_clock_out_disable;
    logic [1:0] mux_select;
    logic       strobe_style_sel;
    logic [1:0] proc_mode;
  } ebc_ctrl0_t;

  // Second processor-mode control register
  typedef struct packed {
    logic [1:0] latch_pin_sel;
    logic [1:0] space_mode;
  } ebc_ctrl1_t;

endpackage

// [src/ebc_sync2.sv]
// Two-flop synchroniser for levels arriving from pins.
// Assumes the destination clock is clk; resets to zero.
`timescale 1ns/1ps
module ebc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule // ebc_sync2

// [src/ebc_space_decode.sv]
// Upper-address decode into the four external spaces for a space mode.
// Assumes the table in the package; purely combinational.
`timescale 1ns/1ps
module ebc_space_decode (
  input  wire logic [7:0] addr_top,
  input  wire logic [1:0] space_mode,
  output logic            hit,
  output logic [1:0]      space_idx
);
  logic [3:0] in_space;

  // One window compare per space
  for (genvar s = 0; s < 4; s++) begin : g_cmp
    assign in_space[s] = (addr_top >= ebc_pkg::EBC_MAP_LO[space_mode][s]) &&
                         (addr_top <= ebc_pkg::EBC_MAP_HI[space_mode][s]);
  end

  // Spaces never overlap, so a plain encoder is enough
  always_comb begin
    hit       = |in_space;
    space_idx = 2'h0;
    for (int s = 0; s < 4; s++) begin
      if (in_space[s]) begin
        space_idx = 2'(s);
      end
    end
  end
endmodule // ebc_space_decode

// [dv/ebc_bus_dev.sv]
// Far-side model: straps plus a simple count of external bus cycles seen.
// Assumes the bus clock of ebc_top; strap levels never move in a run.
`timescale 1ns/1ps
module ebc_bus_dev #(
  parameter logic WIDTH_STRAP = 1'b0
) (
  input  wire logic       clk,
  input  wire logic [2:0] strobe_n,
  output logic            boot_mode_pin,
  output logic            byte_width_pin,
  output logic [15:0]     hits
);
  // Straps held for the whole run, a moving strap is not supported
  assign boot_mode_pin  = 1'b1;
  assign byte_width_pin = WIDTH_STRAP;
  // Any low strobe counts as one access to this device
  initial hits = 16'h0;
  always @(posedge clk) begin
    if (strobe_n != 3'h7) begin
      hits <= hits + 16'h1;
    end
  end
endmodule // ebc_bus_dev

// [dv/ebc_check_monitor.sv]
// Concurrent checks on the ports of ebc_top.
// Assumes one clock domain; bound to every ebc_top instance.
`timescale 1ns/1ps
module ebc_monitor (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 soft_reset,
  input wire logic                 ctrl0_wr,
  input wire ebc_pkg::ebc_access_t acc,
  input wire ebc_pkg::ebc_ctrl0_t  ctrl0,
  input wire ebc_pkg::ebc_ctrl1_t  ctrl1,
  input wire logic                 mode_reg_unlock,
  input wire logic [3:0]           space_width,
  input wire logic [19:0]          addr_pins,
  input wire logic [3:0]           hi_pins,
  input wire logic [3:0]           cs_n,
  input wire logic [2:0]           strobe_n,
  input wire logic                 port1_is_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Locked register must ignore writes
  property p_lock; ctrl0_wr && !mode_reg_unlock && !soft_reset |=> $stable(ctrl0); endproperty
  a_lock: assert property (p_lock) else $error("ctrl0 moved while locked");
  property p_keep; soft_reset |=> ctrl0.proc_mode == $past(ctrl0.proc_mode); endproperty
  a_keep: assert property (p_keep) else $error("proc mode lost on soft reset");
  property p_addr; acc.valid && !acc.internal |=> addr_pins == $past(acc.addr[19:0]); endproperty
  a_addr: assert property (p_addr) else $error("low address wrong");
  property p_int; acc.valid && acc.internal |=> cs_n == 4'hF && $stable(addr_pins); endproperty
  a_int: assert property (p_int) else $error("internal access disturbed bus");
  // Idle cycles hold address and selects and drop strobes
  property p_idle;
    !acc.valid && !soft_reset |=> $stable(addr_pins) && $stable(cs_n) && strobe_n == 3'h7;
  endproperty
  a_idle: assert property (p_idle) else $error("bus moved while idle");
  property p_map;
    acc.valid && !acc.internal && ctrl1.space_mode == 2'h3 && acc.addr[23:20] == 4'h1
      |=> cs_n == 4'hD && hi_pins[2] == 1'b0;
  endproperty
  a_map: assert property (p_map) else $error("space 0 select wrong");
  // Mode 0 leaves the top pins as plain address, top bit inverted
  property p_m0;
    acc.valid && !acc.internal && ctrl1.space_mode == 2'h0
      |=> hi_pins == {~$past(acc.addr[23]), $past(acc.addr[22:20])};
  endproperty
  a_m0: assert property (p_m0) else $error("top address pins wrong");
  property p_p1; !soft_reset |=> port1_is_data == |$past(space_width); endproperty
  a_p1: assert property (p_p1) else $error("port 1 function wrong");
endmodule // ebc_monitor

bind ebc_top ebc_monitor mon (.clk, .rst_b, .soft_reset, .ctrl0_wr, .acc, .ctrl0, .ctrl1,
  .mode_reg_unlock, .space_width, .addr_pins, .hi_pins, .cs_n, .strobe_n, .port1_is_data);

// [dv/tb.sv]
// Self-checking bench for ebc_top: config, selects, strobes, pin functions.
// Assumes ebc_pkg compiled first; the partner model drives both straps.
`timescale 1ns/1ps
module tb;
  logic                 clk, rst_b, soft_reset, boot_mode_pin, byte_width_pin;
  logic                 protect_wr, protect_unlock, ctrl0_wr, ctrl1_wr, width_wr;
  ebc_pkg::ebc_ctrl0_t  ctrl0_wdata, ctrl0;
  ebc_pkg::ebc_ctrl1_t  ctrl1_wdata, ctrl1;
  ebc_pkg::ebc_access_t acc;
  logic [3:0]           width_wdata, space_width, hi_pins, cs_n;
  logic [1:0]           clock_out_sel, mux_lines;
  logic [19:0]          addr_pins;
  logic [2:0]           strobe_n;
  logic                 mode_reg_unlock, boot_mode_seen, port1_is_data;
  logic                 latch_p53, latch_p54, latch_p56, clock_output_pin_en;
  logic [15:0]          hits;
  int                   err_total, checked;

  ebc_top dut (.clk, .rst_b, .soft_reset, .boot_mode_pin, .byte_width_pin, .protect_wr,
    .protect_unlock, .ctrl0_wr, .ctrl0_wdata, .ctrl1_wr, .ctrl1_wdata, .width_wr,
    .width_wdata, .clock_out_sel, .acc, .ctrl0, .ctrl1, .mode_reg_unlock, .space_width,
    .boot_mode_seen, .addr_pins, .hi_pins, .cs_n, .strobe_n, .port1_is_data, .mux_lines,
    .latch_p53, .latch_p54, .latch_p56, .clock_output_pin_en);
  ebc_bus_dev dev (.clk, .strobe_n, .boot_mode_pin, .byte_width_pin, .hits);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic summarize;
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Config write: 0 ctrl0, 1 ctrl1, 2 widths, 3 unlock bit
  task automatic cfg(input int k, input logic [5:0] d);
    @(posedge clk);
    case (k)
      0: begin ctrl0_wr <= 1'b1; ctrl0_wdata <= d; end
      1: begin ctrl1_wr <= 1'b1; ctrl1_wdata <= d[3:0]; end
      2: begin width_wr <= 1'b1; width_wdata <= d[3:0]; end
      default: begin protect_wr <= 1'b1; protect_unlock <= d[0]; end
    endcase
    @(posedge clk);
    {ctrl0_wr, ctrl1_wr, width_wr, protect_wr} <= 4'h0;
    #1;
  endtask

  // One bus request, outputs sampled the cycle after it is taken
  task automatic req(input logic [23:0] a, input logic i, input logic w, input logic [1:0] be);
    @(posedge clk);
    acc <= '{1'b1, i, w, be, a};
    @(posedge clk);
    acc <= '0;
    #1;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk("proc_mode", ctrl0, 6'h03);
    chk("ctrl1", ctrl1, 4'h0);
    chk("cs_n", cs_n, 4'hF);
    chk("hi_pins", hi_pins, 4'h8);
    chk("mux_lines", mux_lines, 2'h0);
    chk("width", space_width, 4'h8);
    chk("port1", port1_is_data, 1'b1);
    chk("boot", boot_mode_seen, 1'b1);
  endtask

  // Space mode 0 here, so only the separate bus code may be written
  task automatic t_lock;
    cfg(0, 6'h07);
    chk("locked ctrl0", ctrl0, 6'h03);
    cfg(3, 6'h01);
    chk("unlock", mode_reg_unlock, 1'b1);
    cfg(0, 6'h07);
    chk("ctrl0", ctrl0, 6'h07);
  endtask

  task automatic t_cs;
    logic [23:0] a[4] = '{24'h100000, 24'h200000, 24'hC00000, 24'hF00000};
    logic [3:0]  s[4] = '{4'hD, 4'hB, 4'h7, 4'hE};
    cfg(0, 6'h03);
    cfg(1, 6'h03);
    for (int i = 0; i < 4; i++) begin
      req(a[i], 1'b0, 1'b0, 2'h3);
      chk("cs_n", cs_n, s[i]);
      chk("hi_pins", hi_pins, {s[i][0], s[i][1], s[i][2], s[i][3]});
      chk("addr", addr_pins, a[i][19:0]);
      chk("no latch", {latch_p56, latch_p54, latch_p53}, 3'h0);
    end
    req(24'h050000, 1'b0, 1'b0, 2'h3);
    chk("unmapped cs", cs_n, 4'hF);
    chk("unmapped strobe", strobe_n, 3'h7);
    // Back-to-back: same space, then internal, then idle
    @(posedge clk);
    acc <= '{1'b1, 1'b0, 1'b0, 2'h3, 24'h100004};
    @(posedge clk);
    acc <= '{1'b1, 1'b0, 1'b0, 2'h3, 24'h100006};
    @(posedge clk);
    acc <= '{1'b1, 1'b1, 1'b0, 2'h3, 24'h000400};
    #1 chk("same space cs", cs_n, 4'hD);
    chk("same space addr", addr_pins, 20'h00006);
    @(posedge clk);
    acc <= '0;
    #1 chk("internal cs", cs_n, 4'hF);
    chk("internal addr", addr_pins, 20'h00006);
    @(posedge clk);
    #1 chk("idle addr", addr_pins, 20'h00006);
    // Modes 1 and 2: fewer selects, the rest of the top pins stay address
    cfg(1, 6'h01);
    req(24'hE00000, 1'b0, 1'b0, 2'h3);
    chk("mode1 cs_n", cs_n, 4'hE);
    chk("mode1 hi_pins", hi_pins, 4'h6);
    cfg(1, 6'h02);
    req(24'h300000, 1'b0, 1'b0, 2'h3);
    chk("mode2 cs_n", cs_n, 4'hD);
    chk("mode2 hi_pins", hi_pins, 4'hB);
    cfg(1, 6'h03);
  endtask

  task automatic t_width;
    cfg(2, 6'h00);
    settle();
    chk("port1 off", port1_is_data, 1'b0);
    cfg(2, 6'h01);
    settle();
    chk("port1 on", port1_is_data, 1'b1);
  endtask

  // Space 0 is 16-bit, space 1 is 8-bit here
  task automatic t_strobe;
    logic [5:0] st[6] = '{6'h03, 6'h03, 6'h03, 6'h07, 6'h07, 6'h07};
    logic [1:0] be[6] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3};
    logic       w[6]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [2:0] ex[6] = '{3'h5, 3'h1, 3'h2, 3'h1, 3'h3, 3'h6};
    for (int i = 0; i < 6; i++) begin
      cfg(0, st[i]);
      req(24'h100010, 1'b0, w[i], be[i]);
      chk("strobes", strobe_n, ex[i]);
    end
    req(24'h200010, 1'b0, 1'b1, 2'h1);
    chk("8-bit strobes", strobe_n[1:0], 2'h1);
  endtask

  task automatic t_mux;
    logic [5:0]  c[6] = '{6'h13, 6'h13, 6'h13, 6'h0B, 6'h0B, 6'h03};
    logic [3:0]  wd[6] = '{4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h1};
    logic [23:0] a[6] = '{24'h100000, 24'h200000, 24'h100000, 24'h200000, 24'h100000,
                          24'h100000};
    logic [1:0]  ex[6] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 6; i++) begin
      cfg(0, c[i]);
      cfg(2, {2'h0, wd[i]});
      req(a[i], 1'b0, 1'b0, 2'h3);
      chk("mux_lines", mux_lines, ex[i]);
    end
  endtask

  task automatic t_latch;
    for (int k = 1; k < 4; k++) begin
      cfg(1, {2'h0, k[1:0], 2'h3});
      req(24'h100000, 1'b0, 1'b0, 2'h3);
      chk("latch", {latch_p56, latch_p54, latch_p53}, 3'h1 << (k - 1));
      @(posedge clk);
      #1 chk("latch end", {latch_p56, latch_p54, latch_p53}, 3'h0);
    end
  endtask

  task automatic t_clk;
    cfg(0, 6'h03);
    settle();
    chk("clk out on", clock_output_pin_en, 1'b1);
    cfg(1, 6'h07);
    settle();
    chk("clk out latch", clock_output_pin_en, 1'b0);
    cfg(1, 6'h0B);
    @(posedge clk);
    clock_out_sel <= 2'h1;
    settle();
    chk("clk out sel", clock_output_pin_en, 1'b0);
    cfg(0, 6'h23);
    @(posedge clk);
    clock_out_sel <= 2'h0;
    settle();
    chk("clk out dis", clock_output_pin_en, 1'b0);
  endtask

  task automatic t_soft;
    cfg(0, 6'h13);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    #1 chk("soft ctrl0", ctrl0, 6'h03);
    chk("soft ctrl1", ctrl1, 4'h0);
    chk("soft width", space_width, 4'h8);
    // Mode 0 again: no selects, top pins plain address with top bit inverted
    req(24'h900000, 1'b0, 1'b0, 2'h3);
    chk("mode0 hi_pins", hi_pins, 4'h1);
    chk("mode0 cs_n", cs_n, 4'hF);
    chk("mode0 strobes", strobe_n, 3'h6);
  endtask

  initial begin
    {rst_b, soft_reset, protect_wr, protect_unlock, ctrl0_wr, ctrl1_wr, width_wr} = 7'h0;
    {ctrl0_wdata, ctrl1_wdata, width_wdata, clock_out_sel, acc} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    settle();
    t_reset();
    t_lock();
    t_cs();
    t_width();
    t_strobe();
    t_mux();
    t_latch();
    t_clk();
    t_soft();
    chk("device hits", {15'h0, hits != 16'h0}, 16'h1);
    summarize();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #100us;
    err_total++;
    summarize();
  end
endmodule // tb
